// ---- core/sdc_pkg.sv ----
package sdc_pkg;
  localparam int DATA_W = 32;
  localparam int LANE_W = 8;
  localparam int MASK_W = 4;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int ADDR_W = 13;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;
  localparam int AP_BIT = 10;
  // mode word layout
  localparam int MR_BL_LSB = 0;
  localparam int MR_BL_W = 3;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_CL_W = 3;
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0020;
  // burst length codes
  localparam logic [MR_BL_W-1:0] BL_1 = 3'h0;
  localparam logic [MR_BL_W-1:0] BL_2 = 3'h1;
  localparam logic [MR_BL_W-1:0] BL_4 = 3'h2;
  localparam logic [MR_BL_W-1:0] BL_8 = 3'h3;
  localparam logic [MR_BL_W-1:0] BL_PAGE = 3'h7;
  localparam logic [MR_CL_W-1:0] CL_3 = 3'h3;
  // column bits that move inside a burst
  localparam logic [COL_W-1:0] SPAN_1 = 9'h000;
  localparam logic [COL_W-1:0] SPAN_2 = 9'h001;
  localparam logic [COL_W-1:0] SPAN_4 = 9'h003;
  localparam logic [COL_W-1:0] SPAN_8 = 9'h007;
  localparam logic [COL_W-1:0] SPAN_PAGE = 9'h1ff;
  localparam logic [COL_W-1:0] COL_ONE = 9'h001;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [MASK_W-1:0] OE_OFF = 4'hf;

  typedef enum logic [3:0] {
    SDC_DESEL, SDC_NOP, SDC_ROW_OPEN, SDC_ROW_CLOSE, SDC_READ, SDC_WRITE,
    SDC_MODE_SET, SDC_BURST_STOP, SDC_REFRESH
  } sdc_cmd_e;

  typedef enum logic [1:0] {SDC_RUN, SDC_PDOWN, SDC_SREF} sdc_pwr_e;
endpackage

// ---- core/sdc_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_mem (
  input wire logic core_clk,
  input wire logic rd_en,
  input wire logic [sdc_pkg::MASK_W-1:0] wr_lane_en,
  input wire logic [sdc_pkg::MEM_AW-1:0] addr,
  input wire logic [sdc_pkg::DATA_W-1:0] wr_data,
  output logic [sdc_pkg::DATA_W-1:0] rd_data
);
  // one array per byte lane so each lane writes on its own
  for (genvar g = 0; g < sdc_pkg::MASK_W; g++) begin : g_lane
    logic [sdc_pkg::LANE_W-1:0] mem [0:(2**sdc_pkg::MEM_AW)-1];
    logic [sdc_pkg::LANE_W-1:0] rd_q;
    always_ff @(posedge core_clk) begin
      if (wr_lane_en[g]) begin
        mem[addr] <= wr_data[g*sdc_pkg::LANE_W +: sdc_pkg::LANE_W];
      end
    end
    // read data held while not read: keeps output frozen in suspend
    always_ff @(posedge core_clk) begin
      if (rd_en) begin
        rd_q <= mem[addr];
      end
    end
    assign rd_data[g*sdc_pkg::LANE_W +: sdc_pkg::LANE_W] = rd_q;
  end
endmodule // sdc_mem
`default_nettype wire

// ---- core/sdc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_gate_in,
  input wire logic sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic wr_sel_n,
  input wire logic [sdc_pkg::BANK_W-1:0] bank_sel,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sdc_pkg::MASK_W-1:0] byte_mask,
  input wire logic [sdc_pkg::DATA_W-1:0] data_in,
  output logic [sdc_pkg::DATA_W-1:0] data_out,
  output logic [sdc_pkg::MASK_W-1:0] data_oe_n,
  output logic [sdc_pkg::NBANK-1:0] bank_open,
  output logic [sdc_pkg::ADDR_W-1:0] mode_word,
  output logic power_down,
  output logic self_refresh,
  output logic clk_suspended,
  output logic refresh_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // clock gate and low power

  logic cke_prev_q;
  logic cke_s1_q;
  logic cke_s2_q;
  logic en;
  logic lp_entry;
  logic all_idle;
  sdc_pkg::sdc_pwr_e pwr_q;
  sdc_pkg::sdc_cmd_e cmd;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cke_prev_q <= 1'b1;
    end else begin
      cke_prev_q <= clk_gate_in;
    end
  end

  // gate is asynchronous while in low power, so it is resynchronised
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cke_s1_q <= 1'b1;
      cke_s2_q <= 1'b1;
    end else begin
      cke_s1_q <= clk_gate_in;
      cke_s2_q <= cke_s1_q;
    end
  end

  // internal clock runs only if the gate was high one edge earlier
  assign en = cke_prev_q && (pwr_q == sdc_pkg::SDC_RUN);

  logic brst_act_q;
  // the synchroniser still shows the old high gate just after entry,
  // so exit waits until the low level has passed through it
  logic lp_armed_q;
  assign lp_entry = en && !clk_gate_in && all_idle && !brst_act_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_q <= sdc_pkg::SDC_RUN;
      lp_armed_q <= 1'b0;
    end else if (pwr_q == sdc_pkg::SDC_RUN) begin
      lp_armed_q <= 1'b0;
      if (lp_entry) begin
        if (cmd == sdc_pkg::SDC_REFRESH) begin
          pwr_q <= sdc_pkg::SDC_SREF;
        end else begin
          pwr_q <= sdc_pkg::SDC_PDOWN;
        end
      end
    end else if (!cke_s2_q) begin
      lp_armed_q <= 1'b1;
    end else if (lp_armed_q) begin
      pwr_q <= sdc_pkg::SDC_RUN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_down <= 1'b0;
      self_refresh <= 1'b0;
      clk_suspended <= 1'b0;
    end else begin
      power_down <= (pwr_q == sdc_pkg::SDC_PDOWN);
      self_refresh <= (pwr_q == sdc_pkg::SDC_SREF);
      clk_suspended <= !cke_prev_q && (pwr_q == sdc_pkg::SDC_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  always_comb begin
    if (!en) begin
      cmd = sdc_pkg::SDC_DESEL;
    end else if (sel_n) begin
      cmd = sdc_pkg::SDC_DESEL;
    end else begin
      unique case ({row_strobe_n, col_strobe_n, wr_sel_n})
        3'b011: cmd = sdc_pkg::SDC_ROW_OPEN;
        3'b010: cmd = sdc_pkg::SDC_ROW_CLOSE;
        3'b101: cmd = sdc_pkg::SDC_READ;
        3'b100: cmd = sdc_pkg::SDC_WRITE;
        3'b000: cmd = sdc_pkg::SDC_MODE_SET;
        3'b110: cmd = sdc_pkg::SDC_BURST_STOP;
        3'b001: cmd = sdc_pkg::SDC_REFRESH;
        3'b111: cmd = sdc_pkg::SDC_NOP;
      endcase
    end
  end

  logic col_cmd;
  assign col_cmd = (cmd == sdc_pkg::SDC_READ) || (cmd == sdc_pkg::SDC_WRITE);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      refresh_pulse <= 1'b0;
    end else begin
      refresh_pulse <= (cmd == sdc_pkg::SDC_REFRESH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode word

  logic [sdc_pkg::ADDR_W-1:0] mode_q;
  logic [sdc_pkg::COL_W-1:0] span;
  logic linear;
  logic cl3;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= sdc_pkg::MR_RESET;
    end else if (cmd == sdc_pkg::SDC_MODE_SET && all_idle) begin
      mode_q <= addr_in;
    end
  end
  assign mode_word = mode_q;

  // unlisted length codes fall back to single beats
  always_comb begin
    unique case (mode_q[sdc_pkg::MR_BL_LSB +: sdc_pkg::MR_BL_W])
      sdc_pkg::BL_1: span = sdc_pkg::SPAN_1;
      sdc_pkg::BL_2: span = sdc_pkg::SPAN_2;
      sdc_pkg::BL_4: span = sdc_pkg::SPAN_4;
      sdc_pkg::BL_8: span = sdc_pkg::SPAN_8;
      sdc_pkg::BL_PAGE: span = sdc_pkg::SPAN_PAGE;
      default: span = sdc_pkg::SPAN_1;
    endcase
  end

  assign linear = !mode_q[sdc_pkg::MR_BT_BIT];
  // any latency code but three runs at two
  assign cl3 = (mode_q[sdc_pkg::MR_CL_LSB +: sdc_pkg::MR_CL_W] == sdc_pkg::CL_3);

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer

  logic brst_wr_q;
  logic brst_ap_q;
  logic [sdc_pkg::BANK_W-1:0] brst_bank_q;
  logic [sdc_pkg::ROW_W-1:0] brst_row_q;
  logic [sdc_pkg::COL_W-1:0] brst_base_q;
  logic [sdc_pkg::COL_W-1:0] brst_cnt_q;
  logic brst_last;
  logic brst_step;
  logic ap_close_old;
  logic ap_close_new;
  logic [sdc_pkg::ROW_W-1:0] row_q [sdc_pkg::NBANK];

  // page bursts wrap and run until stopped or replaced
  assign brst_last = (brst_cnt_q == span) && (span != sdc_pkg::SPAN_PAGE);
  assign brst_step = brst_act_q && !col_cmd && (cmd != sdc_pkg::SDC_BURST_STOP);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      brst_act_q <= 1'b0;
      brst_wr_q <= 1'b0;
      brst_ap_q <= 1'b0;
      brst_bank_q <= '0;
      brst_row_q <= '0;
      brst_base_q <= '0;
      brst_cnt_q <= '0;
    end else if (col_cmd) begin
      brst_act_q <= (span != sdc_pkg::SPAN_1);
      brst_wr_q <= (cmd == sdc_pkg::SDC_WRITE);
      brst_ap_q <= addr_in[sdc_pkg::AP_BIT];
      brst_bank_q <= bank_sel;
      brst_row_q <= row_q[bank_sel];
      brst_base_q <= addr_in[sdc_pkg::COL_W-1:0];
      brst_cnt_q <= sdc_pkg::COL_ONE;
    end else if (cmd == sdc_pkg::SDC_BURST_STOP) begin
      brst_act_q <= 1'b0;
    end else if (en && brst_act_q) begin
      if (brst_last) begin
        brst_act_q <= 1'b0;
      end
      brst_cnt_q <= brst_cnt_q + sdc_pkg::COL_ONE;
    end
  end

  // an interrupted or stopped auto-precharge burst still closes its row
  assign ap_close_old = en && brst_act_q && brst_ap_q &&
                        (brst_last || !brst_step);
  assign ap_close_new = col_cmd && (span == sdc_pkg::SPAN_1) &&
                        addr_in[sdc_pkg::AP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // bank state

  logic [sdc_pkg::NBANK-1:0] open_q;

  for (genvar b = 0; b < sdc_pkg::NBANK; b++) begin : g_bank
    logic hit;
    assign hit = (bank_sel == b[sdc_pkg::BANK_W-1:0]);
    always_ff @(posedge core_clk) begin
      if (rst) begin
        open_q[b] <= 1'b0;
        row_q[b] <= '0;
      end else if (cmd == sdc_pkg::SDC_ROW_OPEN && hit) begin
        open_q[b] <= 1'b1;
        row_q[b] <= addr_in[sdc_pkg::ROW_W-1:0];
      end else if (cmd == sdc_pkg::SDC_ROW_CLOSE &&
                   (addr_in[sdc_pkg::AP_BIT] || hit)) begin
        open_q[b] <= 1'b0;
      end else if ((ap_close_old && brst_bank_q == b[sdc_pkg::BANK_W-1:0]) ||
                   (ap_close_new && hit)) begin
        open_q[b] <= 1'b0;
      end
    end
  end

  assign all_idle = (open_q == '0);
  assign bank_open = open_q;

  ////////////////////////////////////////////////////////////////////////////
  // beat address and memory

  logic beat_go;
  logic beat_wr;
  logic [sdc_pkg::COL_W-1:0] beat_off;
  logic [sdc_pkg::COL_W-1:0] beat_col;
  logic [sdc_pkg::MEM_AW-1:0] beat_addr;
  logic [sdc_pkg::MASK_W-1:0] wr_lane_en;
  logic [sdc_pkg::DATA_W-1:0] mem_rd;

  assign beat_go = col_cmd || (en && brst_step);
  assign beat_wr = col_cmd ? (cmd == sdc_pkg::SDC_WRITE) : brst_wr_q;
  // interleave toggles offset bits, linear adds and wraps in the span
  assign beat_off = linear ? (brst_base_q + brst_cnt_q)
                           : (brst_base_q ^ brst_cnt_q);

  always_comb begin
    if (col_cmd) begin
      beat_col = addr_in[sdc_pkg::COL_W-1:0];
      beat_addr = {bank_sel, row_q[bank_sel], beat_col};
    end else begin
      beat_col = (brst_base_q & ~span) | (beat_off & span);
      beat_addr = {brst_bank_q, brst_row_q, beat_col};
    end
  end

  // a set mask bit drops the matching byte of this beat only
  assign wr_lane_en = {sdc_pkg::MASK_W{beat_go && beat_wr}} & ~byte_mask;

  sdc_mem u_mem (
    .core_clk(core_clk),
    .rd_en(beat_go && !beat_wr),
    .wr_lane_en(wr_lane_en),
    .addr(beat_addr),
    .wr_data(data_in),
    .rd_data(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read latency pipe and output mask

  logic rv0_q;
  logic rv1_q;
  logic rv2_q;
  logic [sdc_pkg::DATA_W-1:0] rd1_q;
  logic [sdc_pkg::DATA_W-1:0] rd2_q;
  logic [sdc_pkg::MASK_W-1:0] m1_q;
  logic [sdc_pkg::MASK_W-1:0] m2_q;
  logic out_vld;

  // whole pipe stalls with the internal clock so output stays frozen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rv0_q <= 1'b0;
      rv1_q <= 1'b0;
      rv2_q <= 1'b0;
      rd1_q <= sdc_pkg::DATA_RESET;
      rd2_q <= sdc_pkg::DATA_RESET;
    end else if (en) begin
      rv0_q <= beat_go && !beat_wr;
      rv1_q <= rv0_q;
      rv2_q <= rv1_q;
      rd1_q <= mem_rd;
      rd2_q <= rd1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      m1_q <= '0;
      m2_q <= '0;
    end else if (en) begin
      m1_q <= byte_mask;
      m2_q <= m1_q;
    end
  end

  assign out_vld = cl3 ? rv2_q : rv1_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_out <= sdc_pkg::DATA_RESET;
      data_oe_n <= sdc_pkg::OE_OFF;
    end else if (en) begin
      data_out <= cl3 ? rd2_q : rd1_q;
      data_oe_n <= ~({sdc_pkg::MASK_W{out_vld}} & ~m2_q);
    end
  end

endmodule // sdc_core
`default_nettype wire

// ---- tb/sdc_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_core_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_gate_in,
  input wire logic sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic wr_sel_n,
  input wire logic [1:0] bank_sel,
  input wire logic [12:0] addr_in,
  input wire logic [3:0] byte_mask,
  input wire logic [31:0] data_out,
  input wire logic [3:0] data_oe_n,
  input wire logic [3:0] bank_open,
  input wire logic [12:0] mode_word,
  input wire logic power_down,
  input wire logic self_refresh
);
  logic gate_q;
  logic go;
  logic [2:0] code;
  // gate history mirrors the device: high out of reset
  always_ff @(posedge core_clk) begin
    gate_q <= rst ? 1'b1 : clk_gate_in;
  end
  assign code = {row_strobe_n, col_strobe_n, wr_sel_n};
  assign go = !sel_n && gate_q && !power_down && !self_refresh;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_open_bank_sel: assert property (go && code == 3'b011 |=> bank_open[$past(bank_sel)])
    else $error("selected bank did not open");
  a_open_needs_cmd: assert property (|(bank_open & ~$past(bank_open)) |-> $past(go)
    && $past(code) == 3'b011) else $error("bank opened without an accepted open");
  a_read_lat_two: assert property (go && code == 3'b101 && clk_gate_in
    && data_oe_n == 4'hf && mode_word[6:4] != 3'h3 ##1 clk_gate_in
    |=> data_oe_n == 4'hf ##1 data_oe_n != 4'hf) else $error("read data not at latency two");
  a_read_lat_three: assert property (go && code == 3'b101 && clk_gate_in
    && data_oe_n == 4'hf && mode_word[6:4] == 3'h3 ##1 clk_gate_in[*2]
    |=> data_oe_n == 4'hf ##1 data_oe_n != 4'hf) else $error("read data not at latency three");
  a_mask_float: assert property (gate_q && clk_gate_in && |byte_mask ##1 clk_gate_in
    |-> ##2 (data_oe_n & $past(byte_mask, 3)) == $past(byte_mask, 3))
    else $error("masked lane still driven two cycles later");
  a_suspend_hold: assert property (!clk_gate_in |-> ##2 $stable(data_out)
    && $stable(data_oe_n)) else $error("outputs moved while clock suspended");
  a_mode_take: assert property (go && code == 3'b000 && bank_open == 4'h0
    |=> mode_word == $past(addr_in)) else $error("mode word not taken from address");
  a_pdown_entry: assert property (gate_q && !clk_gate_in && bank_open == 4'h0
    && data_oe_n == 4'hf && (sel_n || code == 3'b111) && !self_refresh ##1 !clk_gate_in
    |=> power_down) else $error("idle gate low did not enter power down");
  c_cl3_read: cover property (go && code == 3'b101 && mode_word[6:4] == 3'h3);
  c_pdown: cover property ($rose(power_down));
  c_sref: cover property ($rose(self_refresh));
endmodule // sdc_core_props
bind sdc_core sdc_core_props sdc_core_props_i (.core_clk(core_clk), .rst(rst),
  .clk_gate_in(clk_gate_in), .sel_n(sel_n), .row_strobe_n(row_strobe_n),
  .col_strobe_n(col_strobe_n), .wr_sel_n(wr_sel_n), .bank_sel(bank_sel),
  .addr_in(addr_in), .byte_mask(byte_mask), .data_out(data_out), .data_oe_n(data_oe_n),
  .bank_open(bank_open), .mode_word(mode_word), .power_down(power_down),
  .self_refresh(self_refresh));
`default_nettype wire

// ---- tb/sdc_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model (
  input wire logic req_gate,
  input wire logic [3:0] req_code,
  input wire logic [1:0] req_bank,
  input wire logic [12:0] req_addr,
  input wire logic [3:0] req_mask,
  input wire logic [31:0] req_data,
  output logic clk_gate_in,
  output logic sel_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic wr_sel_n,
  output logic [1:0] bank_sel,
  output logic [12:0] addr_in,
  output logic [3:0] byte_mask,
  output logic [31:0] data_in
);
  // pins follow the request at once; the bench paces it to falling edges
  assign clk_gate_in = req_gate;
  assign {sel_n, row_strobe_n, col_strobe_n, wr_sel_n} = req_code;
  // deselected cycles show the inverse so a stale bank or address never looks valid
  assign bank_sel = req_code[3] ? ~req_bank : req_bank;
  assign addr_in = req_code[3] ? ~req_addr : req_addr;
  assign byte_mask = req_mask;
  assign data_in = req_data;
endmodule // sdc_ctrl_model
`default_nettype wire

// ---- tb/tb_sdc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_sdc_core;
  localparam logic [3:0] OPN = 4'h3, CLS = 4'h2, RD = 4'h5, WR = 4'h4, MRS = 4'h0;
  localparam logic [3:0] BST = 4'h6, NOP = 4'h7, RFS = 4'h1;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_gate = 1'b1;
  logic [3:0] req_code = 4'hf;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0;
  logic [3:0] req_mask = 4'h0;
  logic [31:0] req_data = 32'h0;
  wire logic clk_gate_in, sel_n, row_strobe_n, col_strobe_n, wr_sel_n;
  wire logic [1:0] bank_sel;
  wire logic [12:0] addr_in;
  wire logic [3:0] byte_mask;
  wire logic [31:0] data_in;
  logic [31:0] data_out;
  logic [3:0] data_oe_n, bank_open;
  logic [12:0] mode_word;
  logic power_down, self_refresh, clk_suspended, refresh_pulse;
  int miscompares = 0, compares = 0, cyc = 0, cl, bl, bt;
  logic [31:0] mem [logic [23:0]];
  logic [12:0] row_of [4];
  logic [1:0] b;
  logic [8:0] c;
  sdc_core sdc_core_i (.core_clk(core_clk), .rst(rst), .clk_gate_in(clk_gate_in),
    .sel_n(sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .wr_sel_n(wr_sel_n), .bank_sel(bank_sel), .addr_in(addr_in), .byte_mask(byte_mask),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .bank_open(bank_open),
    .mode_word(mode_word), .power_down(power_down), .self_refresh(self_refresh),
    .clk_suspended(clk_suspended), .refresh_pulse(refresh_pulse));
  sdc_ctrl_model sdc_ctrl_model_i (.req_gate(req_gate), .req_code(req_code),
    .req_bank(req_bank), .req_addr(req_addr), .req_mask(req_mask), .req_data(req_data),
    .clk_gate_in(clk_gate_in), .sel_n(sel_n), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .wr_sel_n(wr_sel_n), .bank_sel(bank_sel),
    .addr_in(addr_in), .byte_mask(byte_mask), .data_in(data_in));
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      final_report;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [8:0] beat(input logic [8:0] col, input int n);
    logic [8:0] s;
    s = 9'(bl - 1);
    return (col & ~s) | ((bt != 0 ? col ^ 9'(n) : col + 9'(n)) & s);
  endfunction
  // changes land on the falling edge, half a period clear of sampling
  task automatic cmd(input logic [3:0] cd, input logic [1:0] bk, input logic [12:0] a,
                     input logic [3:0] m, input logic [31:0] d);
    @(negedge core_clk);
    req_code = cd;
    req_bank = bk;
    req_addr = a;
    req_mask = m;
    req_data = d;
  endtask
  // released data lines toggle and bank and address lines take random values so a stale value does not read as valid
  task automatic idle(input logic [3:0] m);
    cmd(NOP, 2'($urandom), 13'($urandom), m, ~req_data);
  endtask
  task automatic refresh;
    cmd(RFS, 2'h0, 13'h0, 4'h0, ~req_data);
  endtask
  task automatic gate(input logic g);
    req_gate = g;
  endtask
  task automatic opn(input logic [1:0] bk);
    row_of[bk] = 13'($urandom);
    cmd(OPN, bk, row_of[bk], 4'h0, $urandom);
  endtask
  task automatic mrs(input logic [12:0] w);
    cmd(CLS, 2'($urandom), 13'h0400, 4'h0, $urandom);
    cmd(MRS, 2'h0, w, 4'h0, $urandom);
    idle(4'h0);
    chk("bank_open", bank_open, 4'h0);
    chk("mode_word", mode_word, w);
  endtask
  task automatic wr(input logic [1:0] bk, input logic [8:0] col, input int n, input bit msk);
    logic [31:0] d;
    logic [3:0] m;
    logic [23:0] k;
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      m = msk ? 4'($urandom) : 4'h0;
      k = {bk, row_of[bk], beat(col, i)};
      for (int j = 0; j < 4; j++) if (!m[j]) mem[k][8*j+:8] = d[8*j+:8];
      cmd(i == 0 ? WR : NOP, bk, {4'h0, col}, m, d);
    end
    if (bl == 512) cmd(BST, bk, 13'h0, 4'h0, $urandom);
  endtask
  task automatic rd(input logic [1:0] bk, input logic [8:0] col, input int n, input bit ap);
    logic [3:0] m;
    logic [31:0] lm;
    m = 4'($urandom_range(0, 14));
    lm = {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
    cmd(RD, bk, {2'h0, ap, 1'b0, col}, m, $urandom);
    for (int t = 1; t <= cl + n; t++) begin
      idle(m);
      if (t > cl) begin
        chk("data_out", data_out & lm, mem[{bk, row_of[bk], beat(col, t - cl - 1)}] & lm);
        chk("data_oe_n", data_oe_n, m);
      end
    end
    chk("auto_close", bank_open[bk], !ap);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h82f95453));
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    chk("rst_oe_n", data_oe_n, 4'hf);
    chk("rst_mode", mode_word, 13'h0020);
    for (int i = 0; i < 16; i++) begin
      cl = 2 + i[3];
      bt = i[2];
      bl = 1 << i[1:0];
      b = 2'($urandom);
      c = 9'($urandom);
      mrs({6'h0, 3'(cl), 1'(bt), 1'b0, 2'(i)});
      opn(b);
      wr(b, c, bl, 1'b0);
      wr(b, c, bl, 1'b1);
      rd(b, c, bl, 1'($urandom));
    end
    cl = 2;
    bt = 0;
    bl = 512;
    mrs(13'h0027);
    opn(2'h1);
    wr(2'h1, 9'h1fe, 4, 1'b0);
    rd(2'h1, 9'h1fe, 4, 1'b0);
    gate(1'b0);
    repeat (3) idle(4'h0);
    chk("suspended", clk_suspended, 1);
    gate(1'b1);
    cmd(BST, 2'h0, 13'h0, 4'h0, $urandom);
    repeat (4) idle(4'h0);
    chk("stop_oe_n", data_oe_n, 4'hf);
    opn(2'h2);
    cmd(CLS, 2'h1, 13'h0, 4'h0, $urandom);
    cmd(4'hb, 2'h0, 13'h0, 4'h0, $urandom);
    idle(4'h0);
    chk("close_one", bank_open, 4'h4);
    cmd(CLS, 2'h1, 13'h0400, 4'h0, $urandom);
    refresh;
    idle(4'h0);
    chk("refresh", refresh_pulse, 1);
    chk("close_all", bank_open, 4'h0);
    gate(1'b0);
    idle(4'h0);
    opn(2'h0);
    repeat (2) idle(4'h0);
    chk("pdown", power_down, 1);
    chk("pdown_open", bank_open, 4'h0);
    gate(1'b1);
    repeat (6) idle(4'h0);
    chk("pdown_exit", power_down, 0);
    refresh;
    gate(1'b0);
    repeat (3) idle(4'h0);
    chk("sref", self_refresh, 1);
    gate(1'b1);
    repeat (6) idle(4'h0);
    chk("sref_exit", self_refresh, 0);
    final_report;
  end
endmodule // tb_sdc_core
`default_nettype wire
